//--- pkg/ptg_pkg.sv
// Purpose: Shared constants and types for the PWM timer with converter trigger
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: All registers reset to zero

package ptg_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_PIN_FUNC = 8'h00;
  localparam logic [7:0] OFS_PIN_DIR = 8'h04;
  localparam logic [7:0] OFS_CONV_CS = 8'h08;
  localparam logic [7:0] OFS_CONV_TSEL = 8'h0C;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h10;
  localparam logic [7:0] OFS_TMR_MODE = 8'h14;
  localparam logic [7:0] OFS_TMR_OUTC = 8'h18;
  localparam logic [7:0] OFS_TMR_START = 8'h1C;
  localparam logic [7:0] OFS_GEN_A = 8'h20;
  localparam logic [7:0] OFS_GEN_B = 8'h24;
  localparam logic [7:0] OFS_GEN_E = 8'h28;
  localparam logic [7:0] OFS_TMR_REQEN = 8'h2C;
  localparam logic [7:0] OFS_CONV_SWST = 8'h30;
  localparam logic [7:0] OFS_CONV_DATA = 8'h34;
  localparam logic [7:0] OFS_TMR_COUNT = 8'h38;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CS_FLAG = 15;
  localparam int CS_IRQ_EN = 14;
  localparam int CS_TRG_EN = 11;
  localparam int CS_TIME_SEL = 8;
  localparam int CS_CLK_LSB = 6;
  localparam int CS_MODE_LSB = 4;
  localparam int CS_SCAN = 3;
  localparam int CS_CH_LSB = 0;
  localparam int PIN0_FUNC_LSB = 0;
  localparam int TCR_CLR_LSB = 5;
  localparam int TCR_EDGE_LSB = 3;
  localparam int TCR_PSC_LSB = 0;
  localparam int TMDR_MD_LSB = 0;
  localparam int TIOR_B_LSB = 4;
  localparam int TIOR_A_LSB = 0;
  localparam int REQEN_E = 7;
  localparam int RES_LSB = 6;

  // ************************************************************
  // Write masks, reserved bits read zero
  // ************************************************************
  localparam logic [15:0] MASK_PIN_FUNC = 16'h7777;
  localparam logic [15:0] MASK_CONV_CS = 16'h5BFF;
  localparam logic [7:0] MASK_TMR_MODE = 8'h7F;
  localparam logic [7:0] MASK_TMR_REQEN = 8'h83;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [2:0] FUNC_TIMER_OUT = 3'h1;
  localparam logic [2:0] FUNC_GPIO = 3'h0;
  localparam logic [15:0] TSEL_TMR0_CMP = 16'h0002;
  localparam logic [2:0] CLR_ON_A = 3'h1;
  localparam logic [2:0] CLR_ON_B = 3'h2;
  localparam logic [2:0] PSC_DIV4 = 3'h1;
  localparam logic [2:0] PSC_DIV16 = 3'h2;
  localparam logic [2:0] PSC_DIV64 = 3'h3;
  localparam logic [3:0] MD_PWM1 = 4'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Conversion timing, in conversion clock states
  // ************************************************************
  localparam logic [15:0] CONV_STATES_STD = 16'h0032;
  localparam logic [15:0] CONV_STATES_ALT = 16'h0040;

  typedef enum logic {CV_IDLE, CV_RUN} ptg_cv_state_t;

  // Cycles of ref clock per conversion, minus one
  function automatic logic [15:0] conv_cycles(input logic conv_time_sel, input logic [1:0] cksl);
    logic [15:0] states;
    states = conv_time_sel ? CONV_STATES_ALT : CONV_STATES_STD;
    unique case (cksl)
      2'h0: conv_cycles = (states << 3) - 16'h0001;
      2'h1: conv_cycles = (states << 2) - 16'h0001;
      2'h2: conv_cycles = (states << 1) - 16'h0001;
      2'h3: conv_cycles = states - 16'h0001;
    endcase
  endfunction : conv_cycles

endpackage : ptg_pkg

//--- rtl/ptg_top.sv
// Purpose: PWM timer channel with compare-output pin and converter it triggers
// Assumes: AXI4-Lite slave, one 20 MHz clock, converter result sampled from inputs
// Notes: All state in one struct; outputs come straight from its flops
// Contract
// - Function 001 routes compare waveform to pin
// - Direction bit 1 drives pin as output
// - Conversion interrupt only while enable bit set
// - Trigger enable starts conversion on timer event
// - Time select 0 gives 50 conversion states
// - Clock select 10 uses clock divided two
// - Mode 00 converts one channel per start
// - Scan bit 0 gives one cycle per start
// - Channel select 000 picks analog input 0
// - Trigger select 0002 picks timer compare match
// - Clear field 001 clears counter on A
// - Edge field 00 counts rising internal edges
// - Prescaler 001 divides timer clock by four
// - Buffer bits 0 keep register pairs independent
// - Mode 0010 selects PWM mode 1
// - Output B 0010 goes high on B
// - Output A 0001 goes low on A
// - Conversion end sets flag, may interrupt
// - Result in bits 15..6, low zero
// - Request enable E lets E match trigger

`timescale 1ns/10ps

module ptg_top #(
  parameter int NUM_AIN = 8,
  parameter int RES_W = 10
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [NUM_AIN*RES_W-1:0] analog_inputs_i,
  output logic compare_out_pin_o,
  output logic compare_out_oe_o,
  output logic conv_end_irq_o
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (NUM_AIN < 1 || NUM_AIN > 8) begin : g_bad_ain
    $error("NUM_AIN must be 1 to 8");
  end
  if (RES_W != 10) begin : g_bad_res
    $error("RES_W must be 10 to fit bits 15 to 6");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic awrdy, wrdy, awgot, wgot, bvalid, arrdy, rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] pin_func, pin_dir, conv_cs, conv_tsel, gen_a, gen_b, gen_e, count, cv_cnt;
    logic [7:0] tmr_ctrl, tmr_mode, tmr_outc, tmr_reqen;
    logic tmr_run, wave, pin, oe, irq;
    logic [5:0] presc;
    ptg_pkg::ptg_cv_state_t cv;
    logic [2:0] cv_ch;
    logic [RES_W-1:0] result;
  } ptg_state_t;

  ptg_state_t st_ff;
  ptg_state_t nxt_st;
  assign s_axi_awready_o = st_ff.awrdy;
  assign s_axi_wready_o = st_ff.wrdy;
  assign s_axi_bvalid_o = st_ff.bvalid;
  assign s_axi_bresp_o = st_ff.bresp;
  assign s_axi_arready_o = st_ff.arrdy;
  assign s_axi_rvalid_o = st_ff.rvalid;
  assign s_axi_rresp_o = st_ff.rresp;
  assign s_axi_rdata_o = st_ff.rdata;
  assign compare_out_pin_o = st_ff.pin;
  assign compare_out_oe_o = st_ff.oe;
  assign conv_end_irq_o = st_ff.irq;

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s, input logic [15:0] m);
    logic [15:0] be;
    be = {{8{s[1]}}, {8{s[0]}}} & m;
    wr16 = (old & ~be) | (d[15:0] & be);
  endfunction : wr16

  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [31:0] d,
                                     input logic [3:0] s, input logic [7:0] m);
    logic [7:0] be;
    be = {8{s[0]}} & m;
    wr8 = (old & ~be) | (d[7:0] & be);
  endfunction : wr8

  // Output level after a compare match for a 4-bit output control code
  function automatic logic out_lvl(input logic [3:0] code, input logic cur);
    unique case (code[1:0])
      2'h0: out_lvl = cur;
      2'h1: out_lvl = 1'b0;
      2'h2: out_lvl = 1'b1;
      2'h3: out_lvl = ~cur;
    endcase
  endfunction : out_lvl

  // ************************************************************
  // Decoded fields
  // ************************************************************
  logic [2:0] clr_src, psc_sel;
  logic [1:0] edge_sel;
  logic [3:0] tmr_md, ctl_a, ctl_b;
  logic [5:0] psc_mask;
  logic ptick, match_a, match_b, match_e, hw_start, sw_start;
  logic conv_start, conv_done, conv_last, wr_go;
  logic [15:0] conv_len;

  always_comb begin
    clr_src = st_ff.tmr_ctrl[ptg_pkg::TCR_CLR_LSB +: 3];
    edge_sel = st_ff.tmr_ctrl[ptg_pkg::TCR_EDGE_LSB +: 2];
    psc_sel = st_ff.tmr_ctrl[ptg_pkg::TCR_PSC_LSB +: 3];
    tmr_md = st_ff.tmr_mode[ptg_pkg::TMDR_MD_LSB +: 4];
    ctl_a = st_ff.tmr_outc[ptg_pkg::TIOR_A_LSB +: 4];
    ctl_b = st_ff.tmr_outc[ptg_pkg::TIOR_B_LSB +: 4];
    unique case (psc_sel)
      ptg_pkg::PSC_DIV4: psc_mask = 6'h03;
      ptg_pkg::PSC_DIV16: psc_mask = 6'h0F;
      ptg_pkg::PSC_DIV64: psc_mask = 6'h3F;
      default: psc_mask = 6'h00;
    endcase
    // Rising edge counts once per divided period; both-edge modes count twice, except undivided, where they count once
    if (edge_sel[1]) begin
      psc_mask = psc_mask >> 1;
    end
    ptick = st_ff.tmr_run && ((st_ff.presc & psc_mask) == psc_mask);
    match_a = ptick && (st_ff.count == st_ff.gen_a);
    match_b = ptick && (st_ff.count == st_ff.gen_b);
    match_e = ptick && (st_ff.count == st_ff.gen_e);
    hw_start = st_ff.conv_cs[ptg_pkg::CS_TRG_EN] && match_e &&
               st_ff.tmr_reqen[ptg_pkg::REQEN_E] &&
               (st_ff.conv_tsel == ptg_pkg::TSEL_TMR0_CMP);
    wr_go = st_ff.awgot && st_ff.wgot && !st_ff.bvalid;
    // Software start is ignored while hardware triggering is selected
    sw_start = wr_go && (st_ff.awaddr == ptg_pkg::OFS_CONV_SWST) && st_ff.wstrb[0] &&
               st_ff.wdata[0] && !st_ff.conv_cs[ptg_pkg::CS_TRG_EN];
    conv_start = (st_ff.cv == ptg_pkg::CV_IDLE) && (hw_start || sw_start);
    conv_len = ptg_pkg::conv_cycles(st_ff.conv_cs[ptg_pkg::CS_TIME_SEL],
                                    st_ff.conv_cs[ptg_pkg::CS_CLK_LSB +: 2]);
    conv_done = (st_ff.cv == ptg_pkg::CV_RUN) && (st_ff.cv_cnt == 16'h0000);
    conv_last = (st_ff.conv_cs[ptg_pkg::CS_MODE_LSB +: 2] == ptg_pkg::MODE_SINGLE) ||
                (st_ff.cv_ch == st_ff.conv_cs[ptg_pkg::CS_CH_LSB +: 3]);
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    // Bus handshakes; address and data may arrive in either order
    if (s_axi_awvalid_i && st_ff.awrdy) begin
      nxt_st.awgot = 1'b1;
      nxt_st.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_ff.wrdy) begin
      nxt_st.wgot = 1'b1;
      nxt_st.wdata = s_axi_wdata_i;
      nxt_st.wstrb = s_axi_wstrb_i;
    end
    if (st_ff.bvalid && s_axi_bready_i) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    // Timer prescaler and counter
    nxt_st.presc = st_ff.tmr_run ? st_ff.presc + 6'h01 : 6'h00;
    if (ptick) begin
      if ((clr_src == ptg_pkg::CLR_ON_A && match_a) ||
          (clr_src == ptg_pkg::CLR_ON_B && match_b)) begin
        nxt_st.count = 16'h0000;
      end else begin
        nxt_st.count = st_ff.count + 16'h0001;
      end
    end
    // Waveform; A match wins when both fall on one tick
    if (!st_ff.tmr_run) begin
      nxt_st.wave = ctl_a[2];
    end else if (match_a) begin
      nxt_st.wave = out_lvl(ctl_a, st_ff.wave);
    end else if (match_b && tmr_md == ptg_pkg::MD_PWM1) begin
      nxt_st.wave = out_lvl(ctl_b, st_ff.wave);
    end
    // Buffer bits stay stored only: general registers A, B, E update directly
    // Converter sequencing
    unique case (st_ff.cv)
      ptg_pkg::CV_IDLE: begin
        if (conv_start) begin
          nxt_st.cv = ptg_pkg::CV_RUN;
          nxt_st.cv_cnt = conv_len;
          nxt_st.cv_ch = (st_ff.conv_cs[ptg_pkg::CS_MODE_LSB +: 2] == ptg_pkg::MODE_SINGLE) ?
                         st_ff.conv_cs[ptg_pkg::CS_CH_LSB +: 3] : 3'h0;
        end
      end
      ptg_pkg::CV_RUN: begin
        if (conv_done) begin
          nxt_st.result = analog_inputs_i[st_ff.cv_ch * RES_W +: RES_W];
          nxt_st.cv_cnt = conv_len;
          if (!conv_last) begin
            nxt_st.cv_ch = st_ff.cv_ch + 3'h1;
          end else if (st_ff.conv_cs[ptg_pkg::CS_SCAN] &&
                       st_ff.conv_cs[ptg_pkg::CS_MODE_LSB +: 2] != ptg_pkg::MODE_SINGLE) begin
            nxt_st.cv_ch = 3'h0;
          end else begin
            nxt_st.cv = ptg_pkg::CV_IDLE;
          end
        end else begin
          nxt_st.cv_cnt = st_ff.cv_cnt - 16'h0001;
        end
      end
    endcase
    // Register writes
    if (wr_go) begin
      nxt_st.awgot = 1'b0;
      nxt_st.wgot = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = ptg_pkg::RESP_OKAY;
      unique case (st_ff.awaddr)
        ptg_pkg::OFS_PIN_FUNC:
          nxt_st.pin_func = wr16(st_ff.pin_func, st_ff.wdata, st_ff.wstrb,
                                 ptg_pkg::MASK_PIN_FUNC);
        ptg_pkg::OFS_PIN_DIR:
          nxt_st.pin_dir = wr16(st_ff.pin_dir, st_ff.wdata, st_ff.wstrb, 16'hFFFF);
        ptg_pkg::OFS_CONV_CS: begin
          nxt_st.conv_cs = wr16(st_ff.conv_cs, st_ff.wdata, st_ff.wstrb,
                                ptg_pkg::MASK_CONV_CS);
          // Writing 0 to the flag clears it
          if (st_ff.wstrb[1] && !st_ff.wdata[ptg_pkg::CS_FLAG]) begin
            nxt_st.conv_cs[ptg_pkg::CS_FLAG] = 1'b0;
          end
        end
        ptg_pkg::OFS_CONV_TSEL:
          nxt_st.conv_tsel = wr16(st_ff.conv_tsel, st_ff.wdata, st_ff.wstrb, 16'hFFFF);
        ptg_pkg::OFS_TMR_CTRL:
          nxt_st.tmr_ctrl = wr8(st_ff.tmr_ctrl, st_ff.wdata, st_ff.wstrb, 8'hFF);
        ptg_pkg::OFS_TMR_MODE:
          nxt_st.tmr_mode = wr8(st_ff.tmr_mode, st_ff.wdata, st_ff.wstrb,
                                ptg_pkg::MASK_TMR_MODE);
        ptg_pkg::OFS_TMR_OUTC:
          nxt_st.tmr_outc = wr8(st_ff.tmr_outc, st_ff.wdata, st_ff.wstrb, 8'hFF);
        ptg_pkg::OFS_TMR_START:
          if (st_ff.wstrb[0]) begin
            nxt_st.tmr_run = st_ff.wdata[0];
          end
        ptg_pkg::OFS_GEN_A: nxt_st.gen_a = wr16(st_ff.gen_a, st_ff.wdata, st_ff.wstrb, 16'hFFFF);
        ptg_pkg::OFS_GEN_B: nxt_st.gen_b = wr16(st_ff.gen_b, st_ff.wdata, st_ff.wstrb, 16'hFFFF);
        ptg_pkg::OFS_GEN_E: nxt_st.gen_e = wr16(st_ff.gen_e, st_ff.wdata, st_ff.wstrb, 16'hFFFF);
        ptg_pkg::OFS_TMR_REQEN:
          nxt_st.tmr_reqen = wr8(st_ff.tmr_reqen, st_ff.wdata, st_ff.wstrb,
                                 ptg_pkg::MASK_TMR_REQEN);
        // Software write to the counter overrides the count on the same edge
        ptg_pkg::OFS_TMR_COUNT:
          nxt_st.count = wr16(st_ff.count, st_ff.wdata, st_ff.wstrb, 16'hFFFF);
        ptg_pkg::OFS_CONV_SWST, ptg_pkg::OFS_CONV_DATA: ;
        default: nxt_st.bresp = ptg_pkg::RESP_SLVERR;
      endcase
    end
    // Conversion end sets the flag after any clear, so the set wins
    if (conv_done && conv_last) begin
      nxt_st.conv_cs[ptg_pkg::CS_FLAG] = 1'b1;
    end
    // Reads answer the cycle after the address is taken
    if (s_axi_arvalid_i && st_ff.arrdy) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = ptg_pkg::RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        ptg_pkg::OFS_PIN_FUNC: nxt_st.rdata[15:0] = st_ff.pin_func;
        ptg_pkg::OFS_PIN_DIR: nxt_st.rdata[15:0] = st_ff.pin_dir;
        ptg_pkg::OFS_CONV_CS: nxt_st.rdata[15:0] = st_ff.conv_cs;
        ptg_pkg::OFS_CONV_TSEL: nxt_st.rdata[15:0] = st_ff.conv_tsel;
        ptg_pkg::OFS_TMR_CTRL: nxt_st.rdata[7:0] = st_ff.tmr_ctrl;
        ptg_pkg::OFS_TMR_MODE: nxt_st.rdata[7:0] = st_ff.tmr_mode;
        ptg_pkg::OFS_TMR_OUTC: nxt_st.rdata[7:0] = st_ff.tmr_outc;
        ptg_pkg::OFS_TMR_START: nxt_st.rdata[0] = st_ff.tmr_run;
        ptg_pkg::OFS_GEN_A: nxt_st.rdata[15:0] = st_ff.gen_a;
        ptg_pkg::OFS_GEN_B: nxt_st.rdata[15:0] = st_ff.gen_b;
        ptg_pkg::OFS_GEN_E: nxt_st.rdata[15:0] = st_ff.gen_e;
        ptg_pkg::OFS_TMR_REQEN: nxt_st.rdata[7:0] = st_ff.tmr_reqen;
        ptg_pkg::OFS_CONV_SWST: nxt_st.rdata[0] = (st_ff.cv == ptg_pkg::CV_RUN);
        ptg_pkg::OFS_CONV_DATA:
          nxt_st.rdata[ptg_pkg::RES_LSB +: RES_W] = st_ff.result;
        ptg_pkg::OFS_TMR_COUNT: nxt_st.rdata[15:0] = st_ff.count;
        default: nxt_st.rresp = ptg_pkg::RESP_SLVERR;
      endcase
    end
    // Ready flags held in flops so outputs come straight from registers
    nxt_st.awrdy = !nxt_st.awgot && !nxt_st.bvalid;
    nxt_st.wrdy = !nxt_st.wgot && !nxt_st.bvalid;
    nxt_st.arrdy = !nxt_st.rvalid;
    // Pin routing
    unique case (st_ff.pin_func[ptg_pkg::PIN0_FUNC_LSB +: 3])
      ptg_pkg::FUNC_TIMER_OUT: begin
        nxt_st.pin = st_ff.wave;
        nxt_st.oe = st_ff.pin_dir[0];
      end
      // No port data register here: plain I/O output drives low
      ptg_pkg::FUNC_GPIO: begin
        nxt_st.pin = 1'b0;
        nxt_st.oe = st_ff.pin_dir[0];
      end
      default: begin
        nxt_st.pin = 1'b0;
        nxt_st.oe = 1'b0;
      end
    endcase
    nxt_st.irq = nxt_st.conv_cs[ptg_pkg::CS_FLAG] && nxt_st.conv_cs[ptg_pkg::CS_IRQ_EN];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking ast_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_conv_end;
    conv_done && conv_last;
  endsequence
  sequence s_div4_tick;
    ptick && psc_sel == ptg_pkg::PSC_DIV4 && edge_sel == 2'h0;
  endsequence

  AST_PIN_ROUTE: assert property (
    st_ff.pin_func[2:0] != ptg_pkg::FUNC_TIMER_OUT |=> !compare_out_pin_o)
    else $error("pin carries waveform without timer function");
  AST_PIN_DIR: assert property (
    st_ff.pin_func[2:0] == ptg_pkg::FUNC_TIMER_OUT |=>
    compare_out_oe_o == $past(st_ff.pin_dir[0]) && compare_out_pin_o == $past(st_ff.wave))
    else $error("pin drive does not follow direction bit");
  AST_IRQ_GATE: assert property (
    conv_end_irq_o |-> st_ff.conv_cs[ptg_pkg::CS_IRQ_EN] && st_ff.conv_cs[ptg_pkg::CS_FLAG])
    else $error("interrupt raised while disabled");
  AST_HW_START: assert property (
    st_ff.cv == ptg_pkg::CV_IDLE && hw_start |=> st_ff.cv == ptg_pkg::CV_RUN ##0
    st_ff.cv_cnt == $past(conv_len))
    else $error("hardware trigger did not start conversion");
  AST_CONV_LEN: assert property (
    $rose(st_ff.cv == ptg_pkg::CV_RUN) && !st_ff.conv_cs[ptg_pkg::CS_TIME_SEL] &&
    st_ff.conv_cs[7:6] == 2'h2 |-> st_ff.cv_cnt == 16'h0063)
    else $error("conversion length not 50 states at clock over two");
  AST_FLAG_SET: assert property (
    s_conv_end |=> st_ff.conv_cs[ptg_pkg::CS_FLAG] ##0
    (st_ff.conv_cs[ptg_pkg::CS_IRQ_EN] == conv_end_irq_o))
    else $error("conversion end did not set flag");
  AST_CLEAR_A: assert property (
    match_a && clr_src == ptg_pkg::CLR_ON_A && !wr_go |=> st_ff.count == 16'h0000)
    else $error("counter not cleared on A match");
  AST_PRESC4: assert property (
    s_div4_tick ##1 (st_ff.tmr_ctrl == $past(st_ff.tmr_ctrl) && st_ff.tmr_run) |->
    !ptick ##1 !ptick ##1 !ptick ##1 ptick)
    else $error("prescaler four ticks wrongly");
  AST_PWM_HIGH: assert property (
    st_ff.tmr_run && match_b && !match_a && tmr_md == ptg_pkg::MD_PWM1 &&
    ctl_b == 4'h2 |=> st_ff.wave)
    else $error("waveform not high after B match");
  AST_RESULT: assert property (
    s_axi_rvalid_o && $past(s_axi_araddr_i) == ptg_pkg::OFS_CONV_DATA &&
    $rose(s_axi_rvalid_o) |-> s_axi_rdata_o[5:0] == 6'h00)
    else $error("result low bits not zero");

endmodule : ptg_top

//--- verif/testbench.sv
// Purpose: Self-checking bench for the PWM timer and converter trigger block
// Assumes: Registers reached over AXI4-Lite, one 50 ns clock
// Notes: Ready and valid are sampled at the falling edge, stable until the next rise
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, pin, oe, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, r;
  logic [79:0] ain = {60'h0, 10'h15A, 10'h2A5};
  int num_errors = 0, samples_checked = 0, hi;
  always #25 ref_clk_i = ~ref_clk_i;
  ptg_top u_ptg_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .analog_inputs_i(ain), .compare_out_pin_o(pin),
    .compare_out_oe_o(oe), .conv_end_irq_o(irq));
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge ref_clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge ref_clk_i);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid & bready; r = bresp;
      @(posedge ref_clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tr;
    @(posedge ref_clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge ref_clk_i);
      ta = arvalid & arready; tr = rvalid & rready; d = rdata; r = rresp;
      @(posedge ref_clk_i);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask : rd
  // Counts pin high cycles over n clocks
  task automatic high_count(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge ref_clk_i);
      if (pin === 1'b1) hi++;
    end
  endtask : high_count
  task automatic t_regs;
    logic [31:0] d;
    rd(ptg_pkg::OFS_CONV_CS, d);
    chk("cs reset", d, 32'h0);
    rd(8'hF0, d);
    chk("unmapped resp", {30'h0, r}, {30'h0, ptg_pkg::RESP_SLVERR});
    wr(ptg_pkg::OFS_TMR_MODE, 32'hFF);
    chk("write resp", {30'h0, r}, {30'h0, ptg_pkg::RESP_OKAY});
    rd(ptg_pkg::OFS_TMR_MODE, d);
    chk("mode mask", d, 32'h7F);
  endtask : t_regs
  task automatic t_soft_conv;
    logic [31:0] d;
    wr(ptg_pkg::OFS_CONV_CS, 32'h4080);
    wr(ptg_pkg::OFS_CONV_SWST, 32'h1);
    // Start edge is one edge before wr returns; flag lands 100 edges after it
    repeat (98) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("irq early", irq, 1'b0);
    @(negedge ref_clk_i);
    chk("irq at end", irq, 1'b1);
    rd(ptg_pkg::OFS_CONV_DATA, d);
    chk("result", d, 32'hA940);
    wr(ptg_pkg::OFS_CONV_CS, 32'h4080);
    chk("flag cleared irq", irq, 1'b0);
  endtask : t_soft_conv
  task automatic t_scan;
    logic [31:0] d;
    wr(ptg_pkg::OFS_CONV_CS, 32'h0091);
    wr(ptg_pkg::OFS_CONV_SWST, 32'h1);
    repeat (230) @(posedge ref_clk_i);
    rd(ptg_pkg::OFS_CONV_DATA, d);
    chk("scan result", d, 32'h5680);
    rd(ptg_pkg::OFS_CONV_SWST, d);
    chk("scan stopped", d, 32'h0);
  endtask : t_scan
  task automatic t_pwm;
    wr(ptg_pkg::OFS_PIN_FUNC, 32'h1);
    wr(ptg_pkg::OFS_PIN_DIR, 32'h1);
    wr(ptg_pkg::OFS_TMR_CTRL, 32'h21);
    wr(ptg_pkg::OFS_TMR_MODE, 32'h02);
    wr(ptg_pkg::OFS_TMR_OUTC, 32'h21);
    wr(ptg_pkg::OFS_GEN_A, 32'h9);
    wr(ptg_pkg::OFS_GEN_B, 32'h4);
    wr(ptg_pkg::OFS_TMR_START, 32'h1);
    repeat (50) @(posedge ref_clk_i);
    chk("oe", oe, 1'b1);
    high_count(40);
    chk("high cycles", hi, 20);
  endtask : t_pwm
  task automatic t_hw_conv;
    logic [31:0] d;
    wr(ptg_pkg::OFS_GEN_E, 32'h3);
    wr(ptg_pkg::OFS_TMR_REQEN, 32'h80);
    wr(ptg_pkg::OFS_CONV_TSEL, 32'h2);
    wr(ptg_pkg::OFS_CONV_CS, 32'h5880);
    repeat (160) @(posedge ref_clk_i);
    chk("hw irq", irq, 1'b1);
    wr(ptg_pkg::OFS_CONV_CS, 32'h1880);
    repeat (300) @(posedge ref_clk_i);
    chk("irq masked", irq, 1'b0);
    rd(ptg_pkg::OFS_CONV_CS, d);
    chk("flag set", d[15], 1'b1);
    wr(ptg_pkg::OFS_PIN_FUNC, 32'h0);
    high_count(40);
    chk("gpio pin", hi, 0);
  endtask : t_hw_conv
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_soft_conv();
    t_scan();
    t_pwm();
    t_hw_conv();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    give_verdict();
  end
endmodule : testbench
